// ---- hdl/dcc_defs.svh ----
// Register offsets, field positions, reset values and timing constants of
// the detection call conditioner. Assumes a 10 MHz clk; included by bare name.
`ifndef DCC_DEFS_SVH
`define DCC_DEFS_SVH

// Register byte offsets on the APB
`define DCC_CTRL_OFF      8'h00
`define DCC_STATUS_OFF    8'h04
`define DCC_FAULT_OFF     8'h08
`define DCC_ZONE_OFF      8'h0c
`define DCC_CHCFG_BASE    8'h20
`define DCC_CALLCNT_BASE  8'h40

// Control register fields
`define DCC_CTRL_FAMEXC   0
`define DCC_CTRL_SOFTFAIL 1
`define DCC_CTRL_RST      2'h0

// Fault register fields (sticky, write one to clear)
`define DCC_FLT_CAM       0
`define DCC_FLT_FRAME     1
`define DCC_FLT_POWER     2

// Channel configuration fields
`define DCC_CH_MODE_LSB   0
`define DCC_CH_FUNC_LSB   2
`define DCC_CH_DIR_BIT    4
`define DCC_CH_DLY_LSB    8
`define DCC_CH_EXT_LSB    16
`define DCC_CH_MASK_LSB   24
`define DCC_CH_CFG_RST    32'h0000_0000

// Timing: times in ns, clock period in ns
`define DCC_CLK_NS        100
`define DCC_TICK_NS       100000000
`define DCC_FRAME_MAX_NS  33333333
`define DCC_PULSE_NS      125000000

`endif

// ---- hdl/dcc_pkg.sv ----
// Types of the detection call conditioner: modes, zone functions, states
// and the packed channel configuration. Needs nothing from outside.
package dcc_pkg;

    // Call conditioning function of one output
    typedef enum logic [1:0] {
        DCC_FULL_DELAY   = 2'h0,
        DCC_NORMAL_DELAY = 2'h1,
        DCC_EXTEND       = 2'h2,
        DCC_DELAY_EXTEND = 2'h3
    } dcc_mode_t;

    // Detector function of one zone
    typedef enum logic [1:0] {
        DCC_PRESENCE     = 2'h0,
        DCC_DIR_PRESENCE = 2'h1,
        DCC_PULSE        = 2'h2,
        DCC_DIR_PULSE    = 2'h3
    } dcc_func_t;

    // Output conditioner states, Gray coded along idle-delay-call-extend
    typedef enum logic [1:0] {
        DCC_ST_IDLE   = 2'b00,
        DCC_ST_DELAY  = 2'b01,
        DCC_ST_CALL   = 2'b11,
        DCC_ST_EXTEND = 2'b10
    } dcc_state_t;

    // One channel configuration word as held in its register
    typedef struct packed {
        logic [7:0] mask;
        logic [7:0] ext;
        logic [7:0] dly;
        logic [2:0] rsv;
        logic       dir_sel;
        dcc_func_t  func;
        dcc_mode_t  mode;
    } dcc_chcfg_t;

endpackage : dcc_pkg

// ---- hdl/dcc_zone.sv ----
// One detection zone: latches occupancy per frame, applies direction and
// turns it into a presence level or a fixed-width pulse per arrival.
// Assumes frame_stb is one clk wide and occupancy is valid with it.
`timescale 1ns/100ps
`default_nettype none
module dcc_zone #(
    parameter logic [23:0] PULSE_CYC = 24'd1250000
) (
    input  wire logic              clk,
    input  wire logic              reset,
    input  wire logic              frame_stb,
    input  wire logic              occ,
    input  wire logic              dir_fwd,
    input  wire logic              dir_sel,
    input  wire dcc_pkg::dcc_func_t func,
    output logic                   demand
);
    logic        is_dir;
    logic        is_pulse;
    logic        qual_nxt;
    logic        qual_r;
    logic        prev_r;
    logic        arrive;
    logic [23:0] pulse_r;

    // Function decode and direction qualification
    assign is_dir   = (func == dcc_pkg::DCC_DIR_PRESENCE) || (func == dcc_pkg::DCC_DIR_PULSE);
    assign is_pulse = (func == dcc_pkg::DCC_PULSE) || (func == dcc_pkg::DCC_DIR_PULSE);
    assign qual_nxt = occ & (~is_dir | (dir_fwd == dir_sel));
    assign arrive   = qual_r & ~prev_r;

    // Occupancy held from frame to frame, each zone on its own
    always_ff @(posedge clk)
    begin
        if (reset)
            qual_r <= 1'b0;
        else if (frame_stb)
            qual_r <= qual_nxt;
    end

    // Arrival edge and fixed-width pulse timer
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            prev_r  <= 1'b0;
            pulse_r <= 24'h0;
        end
        else
        begin
            prev_r <= qual_r;
            if (arrive)
                pulse_r <= PULSE_CYC;
            else if (pulse_r != 24'h0)
                pulse_r <= pulse_r - 24'h1;
        end
    end

    assign demand = is_pulse ? (pulse_r != 24'h0) : qual_r;
endmodule : dcc_zone
`default_nettype wire

// ---- hdl/dcc_cond.sv ----
// One detection call output: delay and extend timing in ticks.
// Assumes tick is one clk wide; green is the assigned phase's green level.
`timescale 1ns/100ps
`default_nettype none
module dcc_cond (
    input  wire logic               clk,
    input  wire logic               reset,
    input  wire logic               tick,
    input  wire logic               demand,
    input  wire logic               green,
    input  wire logic               fam_exc,
    input  wire dcc_pkg::dcc_chcfg_t cfg,
    output logic                    call
);
    dcc_pkg::dcc_state_t st_r;
    dcc_pkg::dcc_state_t st_nxt;
    logic [7:0]          tmr_r;
    logic                delay_on;
    logic                ext_on;
    logic                inhibit;
    logic                clr_tmr;

    // Mode decode; only normal delay looks at green
    assign delay_on = (cfg.mode != dcc_pkg::DCC_EXTEND) && (cfg.dly != 8'h0);
    assign ext_on   = ((cfg.mode == dcc_pkg::DCC_EXTEND) || (cfg.mode == dcc_pkg::DCC_DELAY_EXTEND))
                      && (cfg.ext != 8'h0);
    assign inhibit  = (cfg.mode == dcc_pkg::DCC_NORMAL_DELAY) && green && !fam_exc;
    assign clr_tmr  = (st_nxt != st_r) || (st_r == st_nxt && st_r == dcc_pkg::DCC_ST_CALL);

    // Next state
    always_comb
    begin
        st_nxt = st_r;
        case (st_r)
            dcc_pkg::DCC_ST_IDLE:
                if (demand)
                    st_nxt = (delay_on && !inhibit) ? dcc_pkg::DCC_ST_DELAY
                                                    : dcc_pkg::DCC_ST_CALL;
            dcc_pkg::DCC_ST_DELAY:
                if (!demand)
                    st_nxt = dcc_pkg::DCC_ST_IDLE;
                else if (inhibit || tmr_r >= cfg.dly)
                    st_nxt = dcc_pkg::DCC_ST_CALL;
            dcc_pkg::DCC_ST_CALL:
                if (!demand)
                    st_nxt = ext_on ? dcc_pkg::DCC_ST_EXTEND : dcc_pkg::DCC_ST_IDLE;
            dcc_pkg::DCC_ST_EXTEND:
                if (demand)
                    st_nxt = dcc_pkg::DCC_ST_CALL;
                else if (tmr_r >= cfg.ext)
                    st_nxt = dcc_pkg::DCC_ST_IDLE;
            default:
                st_nxt = dcc_pkg::DCC_ST_IDLE;
        endcase
    end

    // State, timer and registered call
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            st_r  <= dcc_pkg::DCC_ST_IDLE;
            tmr_r <= 8'h0;
            call  <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
            call <= (st_nxt == dcc_pkg::DCC_ST_CALL) || (st_nxt == dcc_pkg::DCC_ST_EXTEND);
            if (clr_tmr)
                tmr_r <= 8'h0;
            else if (tick && tmr_r != 8'hff)
                tmr_r <= tmr_r + 8'h1;
        end
    end
endmodule : dcc_cond
`default_nettype wire

// ---- hdl/dcc_top.sv ----
// Detection call conditioner top: APB registers, frame watchdog, time
// base, eight zones and eight conditioned call outputs with fail-safe.
// Assumes all inputs synchronous to clk and one frame strobe per video frame.
`include "dcc_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module dcc_top #(
    parameter logic [23:0] TICK_CYC      = 24'(`DCC_TICK_NS / `DCC_CLK_NS),
    parameter logic [23:0] FRAME_MAX_CYC = 24'(`DCC_FRAME_MAX_NS / `DCC_CLK_NS),
    parameter logic [23:0] PULSE_CYC     = 24'(`DCC_PULSE_NS / `DCC_CLK_NS)
) (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        frame_stb,
    input  wire logic [7:0]  zone_occ,
    input  wire logic [7:0]  zone_dir,
    input  wire logic [7:0]  phase_green,
    input  wire logic        cam_fail,
    input  wire logic        power_fail,
    output logic      [7:0]  det_call,
    output logic             fail_safe
);
    localparam int NCH = 8;

    // Register state
    logic [1:0]          ctrl_r;
    logic [2:0]          fault_r;
    logic [2:0]          fault_nxt;
    dcc_pkg::dcc_chcfg_t cfg_r [NCH];
    logic [15:0]         cnt_r [NCH];
    logic [31:0]         rdata_nxt;
    logic                err_nxt;

    // Time base, watchdog and per-channel signals
    logic [23:0]         tick_r;
    logic                tick;
    logic [23:0]         wdog_r;
    logic                frame_lost;
    logic                fail_now;
    logic [7:0]          zdem;
    logic [7:0]          chdem;
    logic [7:0]          ccall;
    logic [7:0]          ccall_r;
    logic [7:0]          occ_r;

    // Bus phase decode
    logic                setup;
    logic                wr_acc;
    logic                hit_ctrl;
    logic                hit_stat;
    logic                hit_fault;
    logic                hit_zone;
    logic                hit_cfg;
    logic                hit_cnt;
    logic [2:0]          idx;

    // Match an address to a register or to a bank of eight words
    function automatic logic is_reg(input logic [7:0] a, input logic [7:0] off);
        is_reg = (a == off);
    endfunction : is_reg

    function automatic logic in_bank(input logic [7:0] a, input logic [7:0] base);
        in_bank = (a[7:5] == base[7:5])
                  && (a[1:0] == 2'h0); // Index a[4:2] selects one of eight words
    endfunction : in_bank

    // Setup phase captures read data; access phase completes at once
    assign setup     = psel && !penable;
    assign wr_acc    = psel && penable && pwrite;
    assign pready    = 1'b1;
    assign idx       = paddr[4:2];
    assign hit_ctrl  = is_reg(paddr, `DCC_CTRL_OFF);
    assign hit_stat  = is_reg(paddr, `DCC_STATUS_OFF);
    assign hit_fault = is_reg(paddr, `DCC_FAULT_OFF);
    assign hit_zone  = is_reg(paddr, `DCC_ZONE_OFF);
    assign hit_cfg   = in_bank(paddr, `DCC_CHCFG_BASE);
    assign hit_cnt   = in_bank(paddr, `DCC_CALLCNT_BASE);

    // Read multiplexer
    always_comb
    begin
        rdata_nxt = 32'h0;
        err_nxt   = 1'b0;
        if (hit_ctrl)
            rdata_nxt = {30'h0, ctrl_r};
        else if (hit_stat)
            rdata_nxt = {20'h0, fail_safe, frame_lost, power_fail, cam_fail, ccall_r};
        else if (hit_fault)
            rdata_nxt = {29'h0, fault_r};
        else if (hit_zone)
            rdata_nxt = {16'h0, zdem, occ_r};
        else if (hit_cfg)
            rdata_nxt = cfg_r[idx];
        else if (hit_cnt)
            rdata_nxt = {16'h0, cnt_r[idx]};
        else
            err_nxt = 1'b1;
    end

    // Read data and error are registered in the setup cycle
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            prdata  <= 32'h0;
            pslverr <= 1'b0;
        end
        else if (setup)
        begin
            prdata  <= pwrite ? 32'h0 : rdata_nxt;
            pslverr <= err_nxt || (pwrite && (hit_stat || hit_zone || hit_cnt));
        end
    end

    // Control register: controller family exception and forced fail-safe
    always_ff @(posedge clk)
    begin
        if (reset)
            ctrl_r <= `DCC_CTRL_RST;
        else if (wr_acc && hit_ctrl)
            ctrl_r <= pwdata[1:0];
    end

    // Channel configuration words; each output starts on its own zone
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            for (int i = 0; i < NCH; i++)
            begin
                cfg_r[i]      <= `DCC_CH_CFG_RST;
                cfg_r[i].mask <= 8'(1 << i);
            end
        end
        else if (wr_acc && hit_cfg)
        begin
            cfg_r[idx].mode    <= dcc_pkg::dcc_mode_t'(pwdata[`DCC_CH_MODE_LSB +: 2]);
            cfg_r[idx].func    <= dcc_pkg::dcc_func_t'(pwdata[`DCC_CH_FUNC_LSB +: 2]);
            cfg_r[idx].dir_sel <= pwdata[`DCC_CH_DIR_BIT];
            cfg_r[idx].rsv     <= 3'h0;
            cfg_r[idx].dly     <= pwdata[`DCC_CH_DLY_LSB +: 8];
            cfg_r[idx].ext     <= pwdata[`DCC_CH_EXT_LSB +: 8];
            cfg_r[idx].mask    <= pwdata[`DCC_CH_MASK_LSB +: 8];
        end
    end

    // Sticky faults: a new fault wins over a clear in the same cycle
    always_comb
    begin
        fault_nxt = fault_r;
        if (wr_acc && hit_fault)
            fault_nxt = fault_r & ~pwdata[2:0];
        fault_nxt[`DCC_FLT_CAM]   = fault_nxt[`DCC_FLT_CAM] | cam_fail;
        fault_nxt[`DCC_FLT_FRAME] = fault_nxt[`DCC_FLT_FRAME] | frame_lost;
        fault_nxt[`DCC_FLT_POWER] = fault_nxt[`DCC_FLT_POWER] | power_fail;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
            fault_r <= 3'h0;
        else
            fault_r <= fault_nxt;
    end

    // Timer tick for delay and extend counts, one pulse per tick period
    always_ff @(posedge clk)
    begin
        if (reset)
            tick_r <= 24'h0;
        else if (tick)
            tick_r <= 24'h0;
        else
            tick_r <= tick_r + 24'h1;
    end

    assign tick = (tick_r >= TICK_CYC - 24'h1);

    // Frame watchdog: a frame gap longer than one thirtieth of a second
    // counts as a lost-frame fault
    always_ff @(posedge clk)
    begin
        if (reset)
            wdog_r <= 24'h0;
        else if (frame_stb)
            wdog_r <= 24'h0;
        else if (!frame_lost)
            wdog_r <= wdog_r + 24'h1;
    end

    assign frame_lost = (wdog_r >= FRAME_MAX_CYC);

    // Raw occupancy as last seen, for zone register reads
    always_ff @(posedge clk)
    begin
        if (reset)
            occ_r <= 8'h0;
        else if (frame_stb)
            occ_r <= zone_occ;
    end

    // Zones, each with its own qualification and pulse timer
    for (genvar z = 0; z < NCH; z++)
    begin : g_zone
        dcc_zone #(
            .PULSE_CYC (PULSE_CYC)
        ) u_zone (
            .clk       (clk),
            .reset     (reset),
            .frame_stb (frame_stb),
            .occ       (zone_occ[z]),
            .dir_fwd   (zone_dir[z]),
            .dir_sel   (cfg_r[z].dir_sel),
            .func      (cfg_r[z].func),
            .demand    (zdem[z])
        );
    end

    // Outputs: each gathers the zones in its mask, then conditions the call
    for (genvar c = 0; c < NCH; c++)
    begin : g_out
        assign chdem[c] = |(zdem & cfg_r[c].mask);

        dcc_cond u_cond (
            .clk     (clk),
            .reset   (reset),
            .tick    (tick),
            .demand  (chdem[c]),
            .green   (phase_green[c]),
            .fam_exc (ctrl_r[`DCC_CTRL_FAMEXC]),
            .cfg     (cfg_r[c]),
            .call    (ccall[c])
        );
    end

    // Fail-safe on camera loss, lost frames, power loss or software request
    assign fail_now = cam_fail || power_fail || frame_lost || ctrl_r[`DCC_CTRL_SOFTFAIL];

    // Registered outputs and call counters
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            det_call  <= 8'h0;
            fail_safe <= 1'b0;
            ccall_r   <= 8'h0;
            for (int i = 0; i < NCH; i++)
                cnt_r[i] <= 16'h0;
        end
        else
        begin
            det_call  <= fail_now ? 8'hff : ccall;
            fail_safe <= fail_now;
            ccall_r   <= ccall;
            for (int i = 0; i < NCH; i++)
                if (ccall[i] && !ccall_r[i])
                    cnt_r[i] <= cnt_r[i] + 16'h1;
        end
    end
endmodule : dcc_top
`default_nettype wire

// ---- verification/dcc_top_props.sv ----
// Checker for the call conditioner top: fail-safe, frame watchdog, latency.
// Bound to dcc_top; sees its ports only.
`timescale 1ns/100ps
`default_nettype none
module dcc_top_props #(
    parameter logic [23:0] FRAME_MAX_CYC = 24'd200
) (
    input wire logic        clk,
    input wire logic        reset,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        frame_stb,
    input wire logic [7:0]  zone_occ,
    input wire logic        cam_fail,
    input wire logic        power_fail,
    input wire logic [7:0]  det_call,
    input wire logic        fail_safe
);
    logic [23:0] wd_cnt_r;
    logic [7:0]  occ_r;
    logic        dirty_r;
    wire logic   wr_acc = psel && penable && pwrite;

    // Frame gap count, copy of latched occupancy, channel config touched
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            wd_cnt_r <= 24'h0;
            occ_r    <= 8'h0;
            dirty_r  <= 1'b0;
        end
        else
        begin
            wd_cnt_r <= frame_stb ? 24'h0 : wd_cnt_r + 24'h1;
            occ_r    <= frame_stb ? zone_occ : occ_r;
            dirty_r  <= dirty_r | (wr_acc && paddr >= 8'h20);
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    a_cam_fail_calls:
        assert property (cam_fail |=> det_call == 8'hff)
        else $error("Camera fail: calls low");
    a_cam_fail_flag:
        assert property ($rose(cam_fail) ##1 cam_fail |=> fail_safe)
        else $error("Camera fail: no flag");
    a_power_fail_flag:
        assert property (power_fail |=> fail_safe && det_call == 8'hff)
        else $error("Power fail: no forced calls");
    a_forced_all_calls:
        assert property (fail_safe |-> det_call == 8'hff)
        else $error("Fail-safe with a call low");
    a_soft_fail_calls:
        assert property (wr_acc && paddr == 8'h00 && pwdata[1] |-> ##[1:2] det_call == 8'hff)
        else $error("Soft fail: calls low");
    a_frame_watchdog:
        assert property (wd_cnt_r > FRAME_MAX_CYC + 24'd3 |-> fail_safe)
        else $error("Frame loss: no flag");
    a_presence_latency:
        assert property (frame_stb && !dirty_r && !cam_fail && !power_fail |->
                         ##3 (det_call == 8'hff || det_call == $past(zone_occ, 3)))
        else $error("Presence call late");
    a_zone_readback:
        assert property (psel && !penable && !pwrite && paddr == 8'h0c |=>
                         prdata[7:0] == $past(occ_r))
        else $error("Zone readback wrong");
endmodule : dcc_top_props

bind dcc_top dcc_top_props #(.FRAME_MAX_CYC(FRAME_MAX_CYC)) u_props (.*);
`default_nettype wire

// ---- verification/dcc_ctl_model.sv ----
// Signal controller model: drives the phase greens, counts rises of call 0.
// Sits on the detector outputs of the call conditioner.
`timescale 1ns/100ps
`default_nettype none
module dcc_ctl_model (
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic [7:0] green_req,
    input  wire logic       cnt_clr,
    input  wire logic [7:0] det_call,
    output logic      [7:0] phase_green,
    output logic      [7:0] rise_cnt
);
    logic call0_r;

    // Greens follow the bench's phase plan; each new call on output 0 counted
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            phase_green <= 8'h0;
            call0_r     <= 1'b0;
            rise_cnt    <= 8'h0;
        end
        else
        begin
            phase_green <= green_req;
            call0_r     <= det_call[0];
            rise_cnt    <= cnt_clr ? 8'h0 : rise_cnt + {7'h0, det_call[0] & ~call0_r};
        end
    end
endmodule : dcc_ctl_model
`default_nettype wire

// ---- verification/dcc_top_bench.sv ----
// Bench for the call conditioner: registers, zones, modes, fail-safe.
// Short timing parameters; the bench makes a frame every 20 clocks.
`timescale 1ns/100ps
`default_nettype none
`include "dcc_defs.svh"
module dcc_top_bench;
    logic        clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h0, zone_occ = 8'h0, zone_dir = 8'h0, phase_green, det_call;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, fail_safe, err, cnt_clr = 1'b0;
    logic        frame_stb = 1'b0, cam_fail = 1'b0, power_fail = 1'b0, frames_on = 1'b1;
    logic [7:0]  green_req = 8'h0, rise_cnt, occ_v = 8'h0, dir_v = 8'h0;
    logic [4:0]  fcnt = 5'h0;
    int          failures = 0;
    int          num_checks = 0;

    dcc_top #(.TICK_CYC(24'd10), .FRAME_MAX_CYC(24'd200), .PULSE_CYC(24'd5)) dut (.*);
    dcc_ctl_model u_ctl (.*);

    // Clock, 100 ns period
    always #50 clk = ~clk;

    // Frame strobe every 20 clocks with occupancy and direction
    always @(posedge clk)
    begin
        fcnt      <= (fcnt == 5'd19) ? 5'h0 : fcnt + 5'h1;
        frame_stb <= frames_on && fcnt == 5'd19;
        zone_occ  <= occ_v;
        zone_dir  <= dir_v;
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : finish_test

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++)
        begin
            @(posedge clk);
            if (pready === 1'b1)
                break;
        end
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        check("pready", 32'h1, {31'h0, pready});
        if (n == 20)
            finish_test();
    endtask : apb

    task automatic wcfg(input logic [1:0] md, fn, input logic dr, input logic [7:0] dl, ex);
        apb(1'b1, `DCC_CHCFG_BASE, {8'h1, ex, dl, 3'h0, dr, fn, md});
    endtask : wcfg

    task automatic wait_calls(input logic [7:0] m, v, input int lim, input string what);
        int n;
        for (n = 0; n < lim; n++)
        begin
            @(posedge clk);
            if ((det_call & m) === (v & m))
                break;
        end
        check(what, {24'h0, v & m}, {24'h0, det_call & m});
        if (n == lim)
            finish_test();
    endtask : wait_calls

    task automatic hold_calls(input logic [7:0] m, v, input int cyc, input string what);
        logic bad;
        bad = 1'b0;
        repeat (cyc)
        begin
            @(posedge clk);
            if ((det_call & m) !== (v & m))
                bad = 1'b1;
        end
        check(what, 32'h0, {31'h0, bad});
    endtask : hold_calls

    task automatic sync_frame();
        int n;
        for (n = 0; n < 40 && frame_stb !== 1'b1; n++)
            @(posedge clk);
        check("frame sync", 32'h0, {31'h0, n == 40});
        if (n == 40)
            finish_test();
    endtask : sync_frame

    task automatic do_reset();
        reset <= 1'b1;
        repeat (16) @(posedge clk);
        reset <= 1'b0;
    endtask : do_reset

    task automatic t_regs();
        apb(1'b0, `DCC_CTRL_OFF, 32'h0);
        check("ctrl reset", 32'h0, rd);
        for (int i = 0; i < 8; i++)
        begin
            apb(1'b0, `DCC_CHCFG_BASE + 8'(4 * i), 32'h0);
            check("chcfg reset", {8'h1 << i, 24'h0}, rd);
        end
        apb(1'b0, 8'hfc, 32'h0);
        check("unmapped read", 32'h0, rd);
        check("unmapped error", 32'h1, {31'h0, err});
        apb(1'b1, `DCC_STATUS_OFF, 32'hffff_ffff);
        check("status write refused", 32'h1, {31'h0, err});
        $display("Test registers done");
    endtask : t_regs

    task automatic t_presence();
        occ_v <= 8'ha5;
        wait_calls(8'hff, 8'ha5, 60, "presence calls");
        apb(1'b0, `DCC_ZONE_OFF, 32'h0);
        check("zone readback", 32'ha5a5, {16'h0, rd[15:0]});
        occ_v <= 8'h5a;
        wait_calls(8'hff, 8'h5a, 60, "overlap calls");
        occ_v <= 8'h0;
        wait_calls(8'hff, 8'h0, 60, "calls cleared");
        $display("Test presence done");
    endtask : t_presence

    // Cases: {normal delay, green, family exception, delayed}
    task automatic t_delays();
        logic [3:0] cs [4] = '{4'b0101, 4'b1100, 4'b1001, 4'b1111};
        foreach (cs[k])
        begin
            apb(1'b1, `DCC_CTRL_OFF, {31'h0, cs[k][1]});
            green_req <= {7'h0, cs[k][2]};
            wcfg({1'b0, cs[k][3]}, 2'h0, 1'b0, 8'd3, 8'd0);
            occ_v <= 8'h0;
            wait_calls(8'h1, 8'h0, 60, "delay idle");
            sync_frame();
            occ_v <= 8'h1;
            if (cs[k][0])
                hold_calls(8'h1, 8'h0, 30, "delay running");
            wait_calls(8'h1, 8'h1, cs[k][0] ? 60 : 30, "delay end");
        end
        green_req <= 8'h0;
        apb(1'b1, `DCC_CTRL_OFF, 32'h0);
        occ_v <= 8'h0;
        $display("Test delay modes done");
    endtask : t_delays

    task automatic t_extend();
        wcfg(2'h2, 2'h0, 1'b0, 8'd0, 8'd3);
        occ_v <= 8'h1;
        wait_calls(8'h1, 8'h1, 45, "extend call");
        sync_frame();
        occ_v <= 8'h0;
        hold_calls(8'h1, 8'h1, 35, "extend hold");
        wait_calls(8'h1, 8'h0, 40, "extend end");
        wcfg(2'h3, 2'h0, 1'b0, 8'd3, 8'd4);
        sync_frame();
        occ_v <= 8'h1;
        hold_calls(8'h1, 8'h0, 30, "dx delay");
        wait_calls(8'h1, 8'h1, 60, "dx accept");
        sync_frame();
        occ_v <= 8'h0;
        hold_calls(8'h1, 8'h1, 30, "dx extend");
        occ_v <= 8'h1;
        hold_calls(8'h1, 8'h1, 40, "dx reentry");
        occ_v <= 8'h0;
        wait_calls(8'h1, 8'h0, 80, "dx release");
        sync_frame();
        occ_v <= 8'h1;
        hold_calls(8'h1, 8'h0, 30, "dx new delay");
        wait_calls(8'h1, 8'h1, 60, "dx second accept");
        $display("Test extend modes done");
    endtask : t_extend

    // Wrong-way arrival, leave, right-way arrival, for every zone function
    task automatic t_funcs();
        for (int f = 0; f < 4; f++)
        begin
            wcfg(2'h0, 2'(f), 1'b1, 8'd0, 8'd0);
            occ_v <= 8'h0;
            repeat (50) @(posedge clk);
            cnt_clr <= 1'b1;
            occ_v   <= 8'h1;
            dir_v   <= 8'h0;
            @(posedge clk);
            cnt_clr <= 1'b0;
            repeat (70) @(posedge clk);
            occ_v <= 8'h0;
            repeat (50) @(posedge clk);
            occ_v <= 8'h1;
            dir_v <= 8'h1;
            repeat (70) @(posedge clk);
            check("call rises", f[0] ? 32'd1 : 32'd2, {24'h0, rise_cnt});
            check("call level", {31'h0, ~f[1]}, {31'h0, det_call[0]});
        end
        occ_v <= 8'h0;
        $display("Test zone functions done");
    endtask : t_funcs

    task automatic t_fail();
        for (int s = 0; s < 3; s++)
        begin
            cam_fail   <= (s == 0);
            power_fail <= (s == 1);
            apb(1'b1, `DCC_CTRL_OFF, {30'h0, s == 2, 1'b0});
            repeat (3) @(posedge clk);
            check("forced calls", 32'hff, {24'h0, det_call});
            check("fail flag", 32'h1, {31'h0, fail_safe});
            cam_fail   <= 1'b0;
            power_fail <= 1'b0;
            apb(1'b1, `DCC_CTRL_OFF, 32'h0);
            apb(1'b0, `DCC_FAULT_OFF, 32'h0);
            check("fault sticky", s == 0 ? 32'h1 : (s == 1 ? 32'h4 : 32'h0), rd & 32'h5);
            apb(1'b1, `DCC_FAULT_OFF, 32'h7);
            apb(1'b0, `DCC_FAULT_OFF, 32'h0);
            check("fault cleared", 32'h0, rd & 32'h5);
        end
        $display("Test fail-safe done");
    endtask : t_fail

    task automatic t_watchdog();
        frames_on <= 1'b0;
        repeat (230) @(posedge clk);
        check("frame watchdog", 32'h1, {31'h0, fail_safe});
        check("watchdog calls", 32'hff, {24'h0, det_call});
        frames_on <= 1'b1;
        $display("Test frame watchdog done");
    endtask : t_watchdog

    // Main sequence, with a second reset in mid-run
    initial
    begin
        do_reset();
        t_regs();
        t_presence();
        t_delays();
        t_extend();
        t_funcs();
        t_fail();
        do_reset();
        t_watchdog();
        finish_test();
    end
endmodule : dcc_top_bench
`default_nettype wire
